// *** hw/ppw_timer_map.svh ***
// constants for the pulse period / width measurement timer channel
// Functional notes
// - counter advances on one chosen source: f1, f1/2, f1/8, f1/32 or subclock/32
// - counts up; on effective edge copies count to reload register, clears, continues
// - run bit one starts counting, zero halts; run bits sit at bits 5..7
// - interrupt requested on each effective measurement edge after the first
// - no interrupt for the first effective edge after counting starts
// - overflow requests interrupt and sets the overflow flag at once
// - mode register write at next tick or later clears flag; run must be one
// - software writes never set the overflow flag
// - timer register read returns reload register, not live counter
// - read value undefined until second valid edge after start
// - timer register write changes neither reload register nor counter
`ifndef PPW_TIMER_MAP_SVH
`define PPW_TIMER_MAP_SVH
`define CNT_WIDTH        16
`define CNT_RESET        16'h0000
`define CNT_MAX          16'hFFFF
`define RUN_BIT_LO       5
`define RUN_BIT_HI       7
`define SRC_F1           3'h0
`define SRC_F2           3'h1
`define SRC_F8           3'h2
`define SRC_F32          3'h3
`define SRC_SUBCLOCK_DIV32         3'h4
`define DIV_F2           1'h1
`define DIV_F8           3'h7
`define DIV_F32          5'h1F
`endif

// *** hw/ppw_timer_pkg.sv ***
// types for the pulse period / width measurement timer channel
package ppw_timer_pkg;
   typedef enum logic {
      MEAS_PERIOD,
      MEAS_WIDTH
   } meas_mode_e;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FIRST,
      ST_MEAS
   } run_state_e;
endpackage

// *** hw/pulse_period_width_timer.sv ***
// one channel of the pulse period / width measurement timer
`timescale 1ns/1ns
`include "ppw_timer_map.svh"
module pulse_period_width_timer (
   input  wire logic                  clk_in,
   input  wire logic                  sys_rst_in,
   input  wire logic [2:0]            channel_select_in,
   input  wire logic [2:0]            count_source_in,
   input  wire ppw_timer_pkg::meas_mode_e meas_mode_in,
   input  wire logic                  edge_falling_in,
   input  wire logic                  start_reg_wr_in,
   input  wire logic [7:0]            shared_count_start_reg_in,
   input  wire logic                  channel_mode_reg_wr_in,
   input  wire logic                  channel_value_reg_wr_in,
   input  wire logic [15:0]           channel_value_reg_wdata_in,
   input  wire logic                  subclock_div32_in,
   input  wire logic                  measure_pulse_pin_in,
   output logic [15:0]                channel_value_reg_out,
   output logic                       result_valid_out,
   output logic                       overflow_flag_out,
   output logic                       channel_run_bit_out,
   output logic                       irq_out
);
   // ------------------------------------------------------------
   // count source
   // ------------------------------------------------------------
   logic [4:0] pre_q, pre_d;
   logic       sub_q, sub_d;
   logic       tick;

   function automatic logic src_tick(input logic [2:0] sel, input logic [4:0] pre,
                                     input logic sub_rise);
      case (sel)
         `SRC_F1:   src_tick = 1'b1;
         `SRC_F2:   src_tick = (pre[0] == `DIV_F2);
         `SRC_F8:   src_tick = (pre[2:0] == `DIV_F8);
         `SRC_F32:  src_tick = (pre == `DIV_F32);
         `SRC_SUBCLOCK_DIV32: src_tick = sub_rise;
         default:   src_tick = 1'b0;
      endcase
   endfunction

   always_comb begin
      pre_d = pre_q + 5'h01;
      sub_d = subclock_div32_in;
      tick  = channel_run_bit_out && src_tick(count_source_in, pre_q,
                                             subclock_div32_in && !sub_q);
   end

   // prescaler runs free, so a divided source may tick early after start
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pre_q <= 5'h00;
         sub_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         sub_q <= sub_d;
      end
   end

   // ------------------------------------------------------------
   // measurement edge
   // ------------------------------------------------------------
   logic pin_q, pin_d;
   logic eff_edge;

   always_comb begin
      pin_d = measure_pulse_pin_in;
      if (meas_mode_in == ppw_timer_pkg::MEAS_WIDTH) begin
         eff_edge = pin_q != measure_pulse_pin_in;
      end else if (edge_falling_in) begin
         eff_edge = pin_q && !measure_pulse_pin_in;
      end else begin
         eff_edge = !pin_q && measure_pulse_pin_in;
      end
   end

   // reset level low matches the idle pin, so no false edge follows reset
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= pin_d;
      end
   end

   // ------------------------------------------------------------
   // run control, counter, reload, flag
   // ------------------------------------------------------------
   ppw_timer_pkg::run_state_e st_q, st_d;
   logic [15:0] cnt_q, cnt_d;
   logic [15:0] rld_q, rld_d;
   logic        run_d, irq_d, valid_d;
   logic        run_wr;
   logic        sel_ok;
   logic        wrap;

   // out-of-range selects read as zero instead of indexing past the byte
   function automatic logic run_bit_of(input logic [7:0] start_reg, input logic [2:0] sel);
      case (sel)
         3'h0:    run_bit_of = start_reg[`RUN_BIT_LO];
         3'h1:    run_bit_of = start_reg[`RUN_BIT_LO + 1];
         3'h2:    run_bit_of = start_reg[`RUN_BIT_HI];
         default: run_bit_of = 1'b0;
      endcase
   endfunction

   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      rld_d   = rld_q;
      run_d   = channel_run_bit_out;
      valid_d = result_valid_out;
      irq_d   = 1'b0;
      run_wr  = run_bit_of(shared_count_start_reg_in, channel_select_in);
      sel_ok  = channel_select_in <= 3'(`RUN_BIT_HI - `RUN_BIT_LO);
      wrap    = tick && (cnt_q == `CNT_MAX);
      if (start_reg_wr_in && sel_ok) begin
         run_d = run_wr;
      end
      // a timer-register write is deliberately ignored in this mode
      if (channel_value_reg_wr_in) begin
         rld_d = rld_q;
      end
      if (tick) begin
         cnt_d = cnt_q + 16'h0001;
      end
      if (wrap) begin
         irq_d = 1'b1;
      end
      case (st_q)
         ppw_timer_pkg::ST_IDLE: begin
            if (run_d && !channel_run_bit_out) begin
               st_d    = ppw_timer_pkg::ST_FIRST;
               cnt_d   = `CNT_RESET;
               valid_d = 1'b0;
            end
         end
         ppw_timer_pkg::ST_FIRST: begin
            if (eff_edge) begin
               cnt_d = `CNT_RESET;
               st_d  = ppw_timer_pkg::ST_MEAS;
            end
         end
         ppw_timer_pkg::ST_MEAS: begin
            if (eff_edge) begin
               rld_d   = cnt_q;
               cnt_d   = `CNT_RESET;
               valid_d = 1'b1;
               irq_d   = 1'b1;
            end
         end
         default: st_d = ppw_timer_pkg::ST_IDLE;
      endcase
      if (!run_d) begin
         st_d = ppw_timer_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         st_q                  <= ppw_timer_pkg::ST_IDLE;
         cnt_q                 <= `CNT_RESET;
         rld_q                 <= `CNT_RESET;
         channel_run_bit_out   <= 1'b0;
         result_valid_out      <= 1'b0;
         irq_out               <= 1'b0;
         channel_value_reg_out <= `CNT_RESET;
      end else begin
         st_q                  <= st_d;
         cnt_q                 <= cnt_d;
         rld_q                 <= rld_d;
         channel_run_bit_out   <= run_d;
         result_valid_out      <= valid_d;
         irq_out               <= irq_d;
         // the output mirrors the reload register, never the live count
         channel_value_reg_out <= rld_d;
      end
   end

   // ------------------------------------------------------------
   // overflow flag
   // ------------------------------------------------------------
   logic ovf_d, armed_q, armed_d;

   always_comb begin
      ovf_d   = overflow_flag_out;
      armed_d = armed_q;
      // one tick after the set arms the software clear
      if (tick) begin
         armed_d = overflow_flag_out;
      end
      // clear needs a tick since the set and the run bit still high
      if (channel_mode_reg_wr_in && channel_run_bit_out && armed_q) begin
         ovf_d   = 1'b0;
         armed_d = 1'b0;
      end
      // a wrap in the same cycle as a clear wins; software can only clear
      if (wrap) begin
         ovf_d   = 1'b1;
         armed_d = 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         overflow_flag_out <= 1'b0;
         armed_q           <= 1'b0;
      end else begin
         overflow_flag_out <= ovf_d;
         armed_q           <= armed_d;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   // run control and counting
   run_start_a: assert property (
      st_q == ppw_timer_pkg::ST_IDLE && run_d
      |=> channel_run_bit_out && cnt_q == `CNT_RESET && !result_valid_out)
      else $error("start did not clear counter");
   run_stop_a: assert property (
      start_reg_wr_in && sel_ok && !run_wr |=> !channel_run_bit_out)
      else $error("run bit not cleared");
   stop_a: assert property (
      !channel_run_bit_out |=> $stable(cnt_q) || cnt_q == `CNT_RESET)
      else $error("counted while stopped");
   tick_a: assert property (
      channel_run_bit_out && count_source_in == `SRC_F1 && !eff_edge
      && st_q != ppw_timer_pkg::ST_IDLE |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("f1 count missed");
   no_src_a: assert property (
      count_source_in > `SRC_SUBCLOCK_DIV32 && !eff_edge && st_q != ppw_timer_pkg::ST_IDLE
      |=> $stable(cnt_q))
      else $error("counted with no source");

   // measurement edges
   edge_irq_a: assert property (
      st_q == ppw_timer_pkg::ST_MEAS && eff_edge && run_d |=> irq_out)
      else $error("edge irq missing");
   idle_quiet_a: assert property (
      st_q == ppw_timer_pkg::ST_IDLE |=> !irq_out)
      else $error("irq while stopped");
   first_edge_a: assert property (
      st_q == ppw_timer_pkg::ST_FIRST && eff_edge && !wrap |=> !irq_out)
      else $error("irq on first edge");
   first_hold_a: assert property (
      st_q == ppw_timer_pkg::ST_FIRST |=> $stable(channel_value_reg_out))
      else $error("capture on first edge");
   latch_a: assert property (
      st_q == ppw_timer_pkg::ST_MEAS && eff_edge && run_d
      |=> channel_value_reg_out == $past(cnt_q))
      else $error("capture wrong");
   hold_a: assert property (
      channel_value_reg_wr_in && !eff_edge |=> $stable(channel_value_reg_out))
      else $error("write changed value");
   valid_a: assert property (
      $rose(result_valid_out) |-> $past(st_q) == ppw_timer_pkg::ST_MEAS)
      else $error("valid too early");
   width_a: assert property (
      st_q == ppw_timer_pkg::ST_MEAS && meas_mode_in == ppw_timer_pkg::MEAS_WIDTH
      && pin_q != measure_pulse_pin_in && run_d |=> irq_out)
      else $error("width edge lost");

   // overflow flag; the reset guard keeps a reset clear from looking illegal
   wrap_flag_a: assert property (
      wrap |=> overflow_flag_out && irq_out && cnt_q == `CNT_RESET)
      else $error("overflow not flagged");
   flag_set_a: assert property (
      $rose(overflow_flag_out) |-> $past(wrap))
      else $error("flag set without overflow");
   flag_clear_a: assert property (
      $fell(overflow_flag_out) && !$past(sys_rst_in)
      |-> $past(channel_mode_reg_wr_in) && $past(channel_run_bit_out) && $past(armed_q))
      else $error("bad flag clear");
   flag_keep_a: assert property (
      overflow_flag_out && !channel_mode_reg_wr_in |=> overflow_flag_out)
      else $error("flag lost without write");
   early_clear_a: assert property (
      overflow_flag_out && channel_mode_reg_wr_in && !armed_q |=> overflow_flag_out)
      else $error("flag cleared before a tick");

   // main scenarios
   start_c: cover property (st_q == ppw_timer_pkg::ST_IDLE && run_d);
   meas_c: cover property (st_q == ppw_timer_pkg::ST_MEAS && eff_edge);
   wrap_c: cover property (wrap);
   clear_c: cover property ($fell(overflow_flag_out));
   width_c: cover property (meas_mode_in == ppw_timer_pkg::MEAS_WIDTH && irq_out);
endmodule

// *** verification/pulse_source.sv ***
// model of the external pulse being measured
`timescale 1ns/1ns
module pulse_source (
   input  wire logic        clk_in,
   input  wire logic        en_in,
   input  wire logic [15:0] hi_in,
   input  wire logic [15:0] lo_in,
   output logic             pin_out
);
   logic [15:0] n;
   initial begin
      pin_out = 1'b0;
      n = 16'h0000;
   end
   // moves off the sampling edge; the timer pin is only ever read
   always @(negedge clk_in) begin
      if (en_in) begin
         n = n + 16'h0001;
         if (n >= (pin_out ? hi_in : lo_in)) begin
            pin_out = ~pin_out;
            n = 16'h0000;
         end
      end
   end
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the period / width timer channel
`timescale 1ns/1ns
module testbench;
   logic clk_in, sys_rst_in, start_wr, mode_wr, val_wr, sub, en, p, fall;
   logic [2:0] sel, src;
   logic [3:0] sc;
   logic [7:0] start_d;
   logic [15:0] wdata, hi, lo, gap, exp_v, value;
   ppw_timer_pkg::meas_mode_e mode;
   wire logic pin, valid, flag, run, irq;
   int err_count = 0, samples_checked = 0, irqs = 0, edges = 0;
   int div[5] = '{1, 2, 8, 32, 32};
   logic [31:0] seed = 32'h4186695D;
   pulse_period_width_timer dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .channel_select_in(sel), .count_source_in(src), .meas_mode_in(mode),
      .edge_falling_in(fall), .start_reg_wr_in(start_wr),
      .shared_count_start_reg_in(start_d), .channel_mode_reg_wr_in(mode_wr),
      .channel_value_reg_wr_in(val_wr), .channel_value_reg_wdata_in(wdata),
      .subclock_div32_in(sub), .measure_pulse_pin_in(pin),
      .channel_value_reg_out(value), .result_valid_out(valid),
      .overflow_flag_out(flag), .channel_run_bit_out(run), .irq_out(irq));
   pulse_source src_u (.clk_in(clk_in), .en_in(en), .hi_in(hi), .lo_in(lo), .pin_out(pin));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // subclock already divided: one rising edge every 32 cycles
   always @(negedge clk_in) begin
      sc <= sc + 4'h1;
      if (sc == 4'hF) sub <= ~sub;
   end
   // reference: effective edges and the spacing between them
   always @(posedge clk_in) begin
      p <= pin;
      gap <= gap + 16'h0001;
      if (irq === 1'b1) irqs++;
      if (run === 1'b1 && p != pin && (mode == ppw_timer_pkg::MEAS_WIDTH || pin == !fall)) begin
         edges++;
         exp_v <= gap;
         gap <= 16'h0001;
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(string name, logic [15:0] seen, logic [15:0] expv);
      samples_checked++;
      if (seen !== expv) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, expv, seen);
      end
   endtask
   task automatic strobe(ref logic s);
      s = 1'b1;
      @(negedge clk_in);
      s = 1'b0;
      @(negedge clk_in);
   endtask
   task automatic set_run(logic b);
      @(negedge clk_in);
      start_d = {7'h00, b} << (5 + sel);
      strobe(start_wr);
      check("run bit", {15'h0000, run}, {15'h0000, b});
   endtask
   task automatic measure(int s, logic w, logic f);
      src = 3'(s);
      mode = w ? ppw_timer_pkg::MEAS_WIDTH : ppw_timer_pkg::MEAS_PERIOD;
      fall = f;
      hi = 16'(rnd() % 60 + 20);
      lo = 16'(rnd() % 60 + 20);
      irqs = 0;
      edges = 0;
      set_run(1'b1);
      en = 1'b1;
      repeat (6 * (hi + lo)) @(negedge clk_in);
      en = 1'b0;
      wdata = 16'(rnd());
      strobe(val_wr);
      repeat (3) @(negedge clk_in);
      check("irq count", 16'(irqs), 16'(edges - 1));
      check("result valid", {15'h0000, valid}, 16'h0001);
      if (s == 0) check("result", value, exp_v - 16'h0001);
      else check("scaled", {15'h0000, value + 16'h0001 >= exp_v / div[s]
         && value <= exp_v / div[s] + 16'h0001}, 16'h0001);
      set_run(1'b0);
      $display("measure src %0d width %0b falling %0b done", s, w, f);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {sys_rst_in, start_wr, mode_wr, val_wr, sub, en, p, fall} = 8'h80;
      {sel, src, sc, start_d} = 18'h00000;
      {wdata, hi, lo, gap, exp_v} = 80'h0;
      mode = ppw_timer_pkg::MEAS_PERIOD;
      repeat (6) @(negedge clk_in);
      sys_rst_in = 1'b0;
      // another channel's run bit must leave this one idle
      sel = 3'h1;
      start_d = 8'h20;
      strobe(start_wr);
      check("foreign run bit", {15'h0000, run}, 16'h0000);
      for (int i = 0; i < 12; i++) begin
         sel = 3'(rnd() % 3);
         measure(i % 5, i[1], i[2]);
      end
      src = 3'h0;
      irqs = 0;
      set_run(1'b1);
      repeat (65540) @(negedge clk_in);
      check("overflow flag", {15'h0000, flag}, 16'h0001);
      check("overflow irq", 16'(irqs), 16'h0001);
      set_run(1'b0);
      strobe(mode_wr);
      check("flag while stopped", {15'h0000, flag}, 16'h0001);
      set_run(1'b1);
      strobe(mode_wr);
      check("flag cleared", {15'h0000, flag}, 16'h0000);
      strobe(mode_wr);
      check("flag not set by write", {15'h0000, flag}, 16'h0000);
      $display("overflow test done");
      complete_run();
   end
   // hang guard, well beyond the expected run length
   initial begin
      #950000;
      err_count++;
      complete_run();
   end
endmodule
